// File: hw/aic_param_if.sv
`timescale 1ns/10ps
interface aic_param_if;
  logic wr_en;
  logic [6:0] wr_idx;
  logic [15:0] wr_data;
  logic rd_en;
  logic [6:0] rd_idx;
  logic [15:0] rd_data;
  logic save_req;
  logic busy;
  logic loading;

  modport store (
    input wr_en, wr_idx, wr_data, rd_en, rd_idx, save_req,
    output rd_data, busy, loading
  );
  modport user (
    output wr_en, wr_idx, wr_data, rd_en, rd_idx, save_req,
    input rd_data, busy, loading
  );
endinterface

// File: hw/aic_param_store.sv
`timescale 1ns/10ps
module aic_param_store
  import aic_pkg::*;
#(
  parameter int WORDS = PARAM_WORDS,
  parameter int AW = PARAM_AW
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic resetn,
  // Parameter access
  aic_param_if.store pif
);

  // The nonvolatile copy is never reset, so it survives resetn.
  logic [15:0] ram [WORDS];
  logic [15:0] nvm [WORDS];
  aic_store_t state_q;
  logic [AW-1:0] ptr_q;
  logic [15:0] rd_data_q;

  // ----------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      state_q <= ST_LOAD;
      ptr_q <= '0;
    end else begin
      unique case (state_q)
        ST_LOAD, ST_SAVE: begin
          if (ptr_q == AW'(WORDS - 1)) begin
            state_q <= ST_IDLE;
            ptr_q <= '0;
          end else begin
            ptr_q <= ptr_q + 1'b1;
          end
        end
        ST_IDLE: begin
          if (pif.save_req) begin
            state_q <= ST_SAVE;
          end
        end
        default: begin
          state_q <= ST_IDLE;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Memories
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (state_q == ST_LOAD) begin
      ram[ptr_q] <= nvm[ptr_q];
    end else if (pif.wr_en) begin
      ram[pif.wr_idx] <= pif.wr_data;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (state_q == ST_SAVE) begin
      nvm[ptr_q] <= ram[ptr_q];
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      rd_data_q <= '0;
    end else if (pif.rd_en) begin
      rd_data_q <= ram[pif.rd_idx];
    end
  end

  assign pif.rd_data = rd_data_q;
  assign pif.busy = (state_q != ST_IDLE);
  assign pif.loading = (state_q == ST_LOAD);

endmodule // aic_param_store

// File: hw/aic_pkg.sv
package aic_pkg;

  // ----------------------------------------------------------------
  // Command word bit positions
  // ----------------------------------------------------------------
  localparam int CMD_HS_LO = 0;
  localparam int CMD_HS_HI = 2;
  localparam int CMD_SAVE = 3;
  localparam int CMD_SER_EN = 4;
  localparam int CMD_ALM_CLR = 5;
  localparam int CMD_OOR_CLR = 6;
  localparam int CMD_BANK = 7;
  localparam int CMD_PEAK_LO = 8;

  // ----------------------------------------------------------------
  // Status word bit positions
  // ----------------------------------------------------------------
  localparam int STS_BUSY = 0;
  localparam int STS_RD_DONE = 1;
  localparam int STS_WR_DONE = 2;
  localparam int STS_BAD_DATA = 3;
  localparam int STS_CONV_ERR = 4;
  localparam int STS_ALARM = 5;
  localparam int STS_OOR = 6;
  localparam int STS_GOOD = 7;
  localparam int STS_ACK_LO = 8;

  // ----------------------------------------------------------------
  // Reset values and sizes
  // ----------------------------------------------------------------
  localparam logic [15:0] CMD_RESET = 16'h0000;
  localparam logic [15:0] STS_RESET = 16'h0000;
  localparam int POINTS = 16;
  localparam int BANK_POINTS = 8;

  // ----------------------------------------------------------------
  // Writable parameter map window
  // ----------------------------------------------------------------
  localparam logic [7:0] PARAM_BASE = 8'h2E;
  localparam logic [7:0] PARAM_LAST = 8'h99;
  localparam int PARAM_WORDS = 108;
  localparam int PARAM_AW = 7;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int unsigned CLK_PERIOD_NS = 20;
  localparam int unsigned HB_HALF_NS = 500000000;
  localparam int unsigned HB_HALF_CYC = HB_HALF_NS / CLK_PERIOD_NS;

  // ----------------------------------------------------------------
  // State encodings
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    XF_IDLE = 2'b00,
    XF_BUSY = 2'b01,
    XF_DONE = 2'b11
  } aic_xfer_t;

  typedef enum logic [1:0] {
    ST_LOAD = 2'b00,
    ST_IDLE = 2'b01,
    ST_SAVE = 2'b11
  } aic_store_t;

endpackage

// File: hw/aic_top.sv
`timescale 1ns/10ps
module aic_top
  import aic_pkg::*;
#(
  parameter int unsigned HB_CYC = HB_HALF_CYC
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic resetn,
  // Command word move from controller
  input wire logic cmd_wr,
  input wire logic [15:0] cmd_data,
  // Block transfer handshake from controller machinery
  input wire logic host_transfer_busy,
  input wire logic host_store_done,
  input wire logic host_fetch_done,
  // Block store and fetch data
  input wire logic blk_wr_en,
  input wire logic [7:0] blk_wr_addr,
  input wire logic [15:0] blk_wr_data,
  input wire logic blk_wr_last,
  input wire logic blk_rd_en,
  input wire logic [7:0] blk_rd_addr,
  input wire logic blk_rd_last,
  output logic [15:0] blk_rd_data,
  // Serial port parameter writes
  input wire logic ser_wr_en,
  input wire logic [7:0] ser_wr_addr,
  input wire logic [15:0] ser_wr_data,
  output logic ser_wr_ready,
  // Input point conditions
  input wire logic [15:0] point_enable,
  input wire logic [15:0] point_alarm,
  input wire logic [15:0] point_oor,
  input wire logic conv_fault,
  // Words and controls
  output logic [15:0] cmd_word,
  output logic [15:0] status_word,
  output logic [15:0] peak_clr,
  output logic nvm_busy
);

  localparam int HB_W = $clog2(HB_CYC + 1);

  aic_param_if pif ();

  logic [15:3] cmd_q;
  logic [2:0] hs_q;
  logic save_seen_q;
  logic save_pend_q;
  aic_xfer_t xfer_q;
  logic rd_done_q;
  logic wr_done_q;
  logic bad_q;
  logic conv_err_q;
  logic alm_q;
  logic oor_q;
  logic hb_q;
  logic [HB_W-1:0] hb_cnt_q;
  logic [7:0] ack_q;
  logic [15:0] peak_clr_q;
  logic [15:0] status_q;
  logic ser_take;
  logic wr_any;
  logic [7:0] wr_addr;
  logic wr_in_range;
  logic rd_in_range;

  aic_param_store u_store (
    .sys_clk(sys_clk),
    .resetn(resetn),
    .pif(pif)
  );

  // ----------------------------------------------------------------
  // Command word
  // ----------------------------------------------------------------
  // Word moves only reach bits 3 and up; the low three bits are a
  // copy of the transfer machinery, whatever the move carries.
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      cmd_q <= CMD_RESET[15:3];
    end else if (cmd_wr) begin
      cmd_q <= cmd_data[15:3];
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      hs_q <= CMD_RESET[CMD_HS_HI:CMD_HS_LO];
    end else begin
      hs_q <= {host_fetch_done, host_store_done, host_transfer_busy};
    end
  end

  assign cmd_word = {cmd_q, hs_q};

  // ----------------------------------------------------------------
  // Nonvolatile save
  // ----------------------------------------------------------------
  // A request made while the store is busy waits rather than drops.
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      save_seen_q <= 1'b0;
      save_pend_q <= 1'b0;
    end else begin
      save_seen_q <= cmd_q[CMD_SAVE];
      if (cmd_q[CMD_SAVE] && !save_seen_q) begin
        save_pend_q <= 1'b1;
      end else if (!pif.busy) begin
        save_pend_q <= 1'b0;
      end
    end
  end

  assign pif.save_req = save_pend_q && !pif.busy;
  assign nvm_busy = pif.busy;

  // ----------------------------------------------------------------
  // Parameter writes
  // ----------------------------------------------------------------
  // Block stores win over the serial port, which is told to wait.
  assign ser_wr_ready = cmd_q[CMD_SER_EN] && !blk_wr_en && !pif.loading;
  assign ser_take = ser_wr_en && ser_wr_ready;
  assign wr_any = blk_wr_en || ser_take;
  assign wr_addr = blk_wr_en ? blk_wr_addr : ser_wr_addr;
  assign wr_in_range = (wr_addr >= PARAM_BASE) && (wr_addr <= PARAM_LAST);
  assign pif.wr_en = wr_any && wr_in_range && !pif.loading;
  assign pif.wr_idx = PARAM_AW'(wr_addr - PARAM_BASE);
  assign pif.wr_data = blk_wr_en ? blk_wr_data : ser_wr_data;

  assign rd_in_range = (blk_rd_addr >= PARAM_BASE) &&
                       (blk_rd_addr <= PARAM_LAST);
  assign pif.rd_en = blk_rd_en && rd_in_range;
  assign pif.rd_idx = PARAM_AW'(blk_rd_addr - PARAM_BASE);
  assign blk_rd_data = pif.rd_data;

  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      bad_q <= 1'b0;
    end else if (wr_any) begin
      bad_q <= !wr_in_range;
    end
  end

  // ----------------------------------------------------------------
  // Transfer progress
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      xfer_q <= XF_IDLE;
      rd_done_q <= 1'b0;
      wr_done_q <= 1'b0;
    end else begin
      unique case (xfer_q)
        XF_IDLE: begin
          if (host_transfer_busy) begin
            xfer_q <= XF_BUSY;
            rd_done_q <= 1'b0;
            wr_done_q <= 1'b0;
          end
        end
        XF_BUSY: begin
          if (blk_rd_last || blk_wr_last) begin
            xfer_q <= XF_DONE;
            rd_done_q <= blk_rd_last;
            wr_done_q <= blk_wr_last;
          end
        end
        XF_DONE: begin
          if (!host_transfer_busy) begin
            xfer_q <= XF_IDLE;
          end
        end
        default: begin
          xfer_q <= XF_IDLE;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Error and summary flags
  // ----------------------------------------------------------------
  // A new event in the clearing cycle keeps the flag set.
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      conv_err_q <= 1'b0;
      alm_q <= 1'b0;
      oor_q <= 1'b0;
    end else begin
      conv_err_q <= conv_err_q || conv_fault;
      alm_q <= (|(point_alarm & point_enable)) ||
               (alm_q && !cmd_q[CMD_ALM_CLR]);
      oor_q <= (|point_oor) || (oor_q && !cmd_q[CMD_OOR_CLR]);
    end
  end

  // ----------------------------------------------------------------
  // Heartbeat
  // ----------------------------------------------------------------
  // A latched conversion fault stops the heartbeat low; the controller
  // also sees it in the conversion error bit of the status word.
  always_ff @(posedge sys_clk) begin
    if (!resetn || conv_err_q) begin
      hb_cnt_q <= '0;
      hb_q <= 1'b0;
    end else if (hb_cnt_q == HB_W'(HB_CYC - 1)) begin
      hb_cnt_q <= '0;
      hb_q <= !hb_q;
    end else begin
      hb_cnt_q <= hb_cnt_q + 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // Peak hold clears
  // ----------------------------------------------------------------
  // Changing the bank while an acknowledge stands is not caught here.
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      ack_q <= '0;
      peak_clr_q <= '0;
    end else begin
      peak_clr_q <= '0;
      for (int i = 0; i < BANK_POINTS; i++) begin
        ack_q[i] <= cmd_q[CMD_PEAK_LO + i];
        if (cmd_q[CMD_PEAK_LO + i] && !ack_q[i]) begin
          if (cmd_q[CMD_BANK]) begin
            peak_clr_q[i + BANK_POINTS] <= 1'b1;
          end else begin
            peak_clr_q[i] <= 1'b1;
          end
        end
      end
    end
  end

  assign peak_clr = peak_clr_q;

  // ----------------------------------------------------------------
  // Status word
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      status_q <= STS_RESET;
    end else begin
      status_q[STS_BUSY] <= (xfer_q == XF_BUSY) || pif.busy;
      status_q[STS_RD_DONE] <= rd_done_q;
      status_q[STS_WR_DONE] <= wr_done_q;
      status_q[STS_BAD_DATA] <= bad_q;
      status_q[STS_CONV_ERR] <= conv_err_q;
      status_q[STS_ALARM] <= alm_q;
      status_q[STS_OOR] <= oor_q;
      status_q[STS_GOOD] <= hb_q;
      status_q[15:STS_ACK_LO] <= ack_q;
    end
  end

  assign status_word = status_q;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!resetn);

  a_hs_bits_own: assert property (
    cmd_wr |=> cmd_word[2:0] ==
      {$past(host_fetch_done), $past(host_store_done),
       $past(host_transfer_busy)})
    else $error("handshake bits taken from word move");
  a_save_starts: assert property (
    $rose(cmd_word[CMD_SAVE]) && !nvm_busy |-> ##[1:3] nvm_busy)
    else $error("save request did not start store");
  a_load_boot: assert property (
    $rose(resetn) |-> nvm_busy ##1 nvm_busy)
    else $error("startup load not running");
  a_ser_gated: assert property (
    ser_wr_en && !cmd_word[CMD_SER_EN] && !blk_wr_en |-> !pif.wr_en)
    else $error("serial write taken while disabled");
  a_alarm_clear: assert property (
    cmd_word[CMD_ALM_CLR] && !(|(point_alarm & point_enable))
      |-> ##2 !status_word[STS_ALARM])
    else $error("alarm flag not cleared");
  a_oor_clear: assert property (
    cmd_word[CMD_OOR_CLR] && !(|point_oor) |-> ##2 !status_word[STS_OOR])
    else $error("range flag not cleared");
  a_peak_bank: assert property (
    cmd_word[CMD_PEAK_LO] && !ack_q[0] |=>
      ($past(cmd_word[CMD_BANK]) ? peak_clr[8] && !peak_clr[0]
                                 : peak_clr[0] && !peak_clr[8]))
    else $error("peak clear went to wrong bank");
  a_peak_once: assert property (
    peak_clr[3] || peak_clr[11] |=> !peak_clr[3] && !peak_clr[11])
    else $error("peak clear longer than one cycle");
  a_busy_flag: assert property (
    host_transfer_busy && xfer_q == XF_IDLE |-> ##2 status_word[STS_BUSY])
    else $error("busy flag missing");
  a_bad_set: assert property (
    blk_wr_en && blk_wr_addr > PARAM_LAST |-> ##2 status_word[STS_BAD_DATA])
    else $error("invalid data flag not set");
  a_bad_clear: assert property (
    blk_wr_en && blk_wr_addr >= PARAM_BASE && blk_wr_addr <= PARAM_LAST
      |-> ##2 !status_word[STS_BAD_DATA])
    else $error("invalid data flag not cleared");
  a_conv_set: assert property (
    conv_fault |-> ##2 status_word[STS_CONV_ERR][*3])
    else $error("conversion flag not held");
  a_alarm_set: assert property (
    |(point_alarm & point_enable) |-> ##2 status_word[STS_ALARM])
    else $error("alarm flag not set");
  a_oor_set: assert property (
    |point_oor |-> ##2 status_word[STS_OOR])
    else $error("range flag not set");
  a_hb_toggle: assert property (
    hb_cnt_q == HB_W'(HB_CYC - 1) && !conv_err_q
      |-> ##2 status_word[STS_GOOD] != $past(status_word[STS_GOOD]))
    else $error("heartbeat did not toggle");
  a_ack_track: assert property (
    cmd_word[CMD_PEAK_LO] |-> ##2 status_word[STS_ACK_LO])
    else $error("peak acknowledge missing");
  a_ack_drop: assert property (
    !cmd_word[CMD_PEAK_LO] |-> ##2 !status_word[STS_ACK_LO])
    else $error("acknowledge outlived its request");

  c_save: cover property ($rose(cmd_word[CMD_SAVE]) ##[1:3] nvm_busy);
  c_bank_hi: cover property (peak_clr[15]);
  c_wr_done: cover property ($rose(status_word[STS_WR_DONE]));
  c_hb: cover property ($rose(status_word[STS_GOOD]));

endmodule // aic_top

// File: verif/aic_host_model.sv
`timescale 1ns/10ps
// --------------------------------------------------------------
// Controller model: moves the command word, runs block transfers.
// --------------------------------------------------------------
module aic_host_model (
  // Clock
  input wire logic sys_clk,
  // Word move and transfer handshake
  output logic cmd_wr,
  output logic [15:0] cmd_data,
  output logic host_transfer_busy,
  output logic host_store_done,
  output logic host_fetch_done,
  // Block store and fetch
  output logic blk_wr_en,
  output logic [7:0] blk_wr_addr,
  output logic [15:0] blk_wr_data,
  output logic blk_wr_last,
  output logic blk_rd_en,
  output logic [7:0] blk_rd_addr,
  output logic blk_rd_last,
  input wire logic [15:0] blk_rd_data
);
  initial begin
    {cmd_wr, host_transfer_busy, host_store_done, host_fetch_done} = '0;
    {blk_wr_en, blk_wr_last, blk_rd_en, blk_rd_last} = '0;
    {cmd_data, blk_wr_data, blk_wr_addr, blk_rd_addr} = '0;
  end
  task automatic step();
    @(posedge sys_clk);
    #1;
  endtask
  // Released lines show the inverse of their last value, not a hold.
  task automatic word_move(input logic [15:0] w, input logic raw);
    cmd_wr = 1'b1;
    cmd_data = raw ? w : {w[15:3], 3'h0};
    step();
    cmd_wr = 1'b0;
    cmd_data = ~cmd_data;
    step();
  endtask
  task automatic xfer(input logic on);
    host_transfer_busy = on;
    {host_store_done, host_fetch_done} = 2'b00;
    step();
  endtask
  task automatic block_write(input logic [7:0] a, input logic [15:0] d,
                             input logic last);
    {blk_wr_en, blk_wr_addr, blk_wr_data, blk_wr_last} = {1'b1, a, d, last};
    step();
    {blk_wr_en, blk_wr_last} = 2'b00;
    {blk_wr_addr, blk_wr_data} = {~a, ~d};
    host_store_done = host_store_done | last;
    step();
  endtask
  task automatic block_read(input logic [7:0] a, input logic last,
                            output logic [15:0] d);
    {blk_rd_en, blk_rd_addr, blk_rd_last} = {1'b1, a, last};
    step();
    {blk_rd_en, blk_rd_addr, blk_rd_last} = {1'b0, ~a, 1'b0};
    host_fetch_done = host_fetch_done | last;
    d = blk_rd_data;
    step();
  endtask
endmodule // aic_host_model

// File: verif/testbench.sv
`timescale 1ns/10ps
module testbench;
  import aic_pkg::*;
  // A short heartbeat keeps the run small; checks scale with it.
  localparam int unsigned HB = 8;
  localparam int LIMIT = 5000;
  logic sys_clk, resetn, ser_wr_en, ser_wr_ready, conv_fault, nvm_busy;
  logic cmd_wr, host_transfer_busy, host_store_done, host_fetch_done;
  logic blk_wr_en, blk_wr_last, blk_rd_en, blk_rd_last;
  logic [7:0] blk_wr_addr, blk_rd_addr, ser_wr_addr;
  logic [15:0] cmd_data, blk_wr_data, blk_rd_data, ser_wr_data;
  logic [15:0] point_enable, point_alarm, point_oor;
  logic [15:0] cmd_word, status_word, peak_clr;
  int mismatches = 0;
  int compares = 0;
  int cycles = 0;

  aic_top #(.HB_CYC(HB)) dut_u (
    .sys_clk(sys_clk), .resetn(resetn), .cmd_wr(cmd_wr),
    .cmd_data(cmd_data), .host_transfer_busy(host_transfer_busy),
    .host_store_done(host_store_done), .host_fetch_done(host_fetch_done),
    .blk_wr_en(blk_wr_en), .blk_wr_addr(blk_wr_addr),
    .blk_wr_data(blk_wr_data), .blk_wr_last(blk_wr_last),
    .blk_rd_en(blk_rd_en), .blk_rd_addr(blk_rd_addr),
    .blk_rd_last(blk_rd_last), .blk_rd_data(blk_rd_data),
    .ser_wr_en(ser_wr_en), .ser_wr_addr(ser_wr_addr),
    .ser_wr_data(ser_wr_data), .ser_wr_ready(ser_wr_ready),
    .point_enable(point_enable), .point_alarm(point_alarm),
    .point_oor(point_oor), .conv_fault(conv_fault),
    .cmd_word(cmd_word), .status_word(status_word),
    .peak_clr(peak_clr), .nvm_busy(nvm_busy)
  );
  aic_host_model host_u (
    .sys_clk(sys_clk), .cmd_wr(cmd_wr), .cmd_data(cmd_data),
    .host_transfer_busy(host_transfer_busy),
    .host_store_done(host_store_done), .host_fetch_done(host_fetch_done),
    .blk_wr_en(blk_wr_en), .blk_wr_addr(blk_wr_addr),
    .blk_wr_data(blk_wr_data), .blk_wr_last(blk_wr_last),
    .blk_rd_en(blk_rd_en), .blk_rd_addr(blk_rd_addr),
    .blk_rd_last(blk_rd_last), .blk_rd_data(blk_rd_data)
  );

  initial begin
    sys_clk = 1'b0;
    forever #10 sys_clk = ~sys_clk;
  end
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == LIMIT) begin
      mismatches++;
      print_verdict();
    end
  end

  // --------------------------------------------------------------
  // Helpers
  // --------------------------------------------------------------
  task automatic print_verdict();
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  task automatic check_word(input logic [15:0] got, input logic [15:0] exp);
    compares++;
    if (got !== exp) begin
      mismatches++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic check_bit(input logic got, input logic exp);
    check_word({15'h0000, got}, {15'h0000, exp});
  endtask
  task automatic step();
    @(posedge sys_clk);
    #1;
  endtask
  task automatic step_n(input int n);
    repeat (n) step();
  endtask
  function automatic logic [15:0] peak_mask(input logic bank, input int i);
    return 16'h0001 << (i + (bank ? BANK_POINTS : 0));
  endfunction
  function automatic logic [15:0] cmd_view(input logic [15:0] w);
    return {w[15:3], 3'h0};
  endfunction
  task automatic ser_write(input logic [7:0] a);
    ser_wr_en = 1'b1;
    ser_wr_addr = a;
    ser_wr_data = 16'($urandom);
    step();
    ser_wr_en = 1'b0;
    ser_wr_addr = ~a;
    ser_wr_data = ~ser_wr_data;
    step_n(2);
  endtask
  task automatic wait_load();
    for (int k = 0; k < 200 && nvm_busy !== 1'b0; k++) begin
      step();
    end
    check_bit(nvm_busy, 1'b0);
  endtask

  // --------------------------------------------------------------
  // Main sequence
  // --------------------------------------------------------------
  initial begin
    logic [15:0] w, d, got;
    logic bank, hb;
    int i, n, k;
    void'($urandom(32'h0d3a2330));
    {resetn, ser_wr_en, conv_fault, ser_wr_addr, ser_wr_data} = '0;
    {point_enable, point_alarm, point_oor} = '0;
    step_n(12);
    check_word(cmd_word, CMD_RESET);
    check_word(status_word, STS_RESET);
    resetn = 1'b1;
    wait_load();
    w = 16'($urandom) & 16'hFFF0;
    host_u.word_move(w | 16'h0007, 1'b1);
    check_word(cmd_word, cmd_view(w));
    host_u.word_move(16'h0000, 1'b0);
    step_n(3);
    host_u.xfer(1'b1);
    step_n(2);
    check_bit(status_word[STS_BUSY], 1'b1);
    check_bit(cmd_word[0], 1'b1);
    d = 16'($urandom);
    host_u.block_write(PARAM_BASE, d, 1'b1);
    step_n(2);
    check_word(16'(status_word[2:1]), 16'h0002);
    check_bit(cmd_word[1], 1'b1);
    host_u.xfer(1'b0);
    step_n(2);
    check_word(16'(status_word[2:0]), 16'h0004);
    check_word(16'(cmd_word[2:0]), 16'h0000);
    host_u.xfer(1'b1);
    host_u.block_read(PARAM_BASE, 1'b1, got);
    check_word(got, d);
    step_n(2);
    check_word(16'(status_word[2:1]), 16'h0001);
    check_bit(cmd_word[2], 1'b1);
    host_u.xfer(1'b0);
    step_n(2);
    // Invalid data flag through both paths, and serial gating.
    host_u.word_move(16'h0010, 1'b0);
    check_bit(ser_wr_ready, 1'b1);
    ser_write(8'($urandom_range(45)));
    check_bit(status_word[STS_BAD_DATA], 1'b1);
    host_u.word_move(16'h0000, 1'b0);
    check_bit(ser_wr_ready, 1'b0);
    ser_write(PARAM_LAST);
    check_bit(status_word[STS_BAD_DATA], 1'b1);
    host_u.word_move(16'h0010, 1'b0);
    ser_write(8'($urandom_range(153, 46)));
    check_bit(status_word[STS_BAD_DATA], 1'b0);
    host_u.block_write(8'($urandom_range(255, 154)), d, 1'b0);
    step();
    check_bit(status_word[STS_BAD_DATA], 1'b1);
    host_u.block_write(PARAM_BASE, d, 1'b0);
    step();
    check_bit(status_word[STS_BAD_DATA], 1'b0);
    // Peak clears over both banks.
    for (i = 0; i < 6; i++) begin
      bank = i[0];
      n = $urandom_range(7);
      w = (16'h0100 << n) | (16'(bank) << CMD_BANK);
      host_u.word_move(w, 1'b0);
      for (k = 0; k < 4 && peak_clr === 16'h0000; k++) begin
        step();
      end
      check_word(peak_clr, peak_mask(bank, n));
      step();
      check_word(peak_clr, 16'h0000);
      check_word(16'(status_word[15:8]), 16'(w[15:8]));
      step_n(4);
      check_word(16'(status_word[15:8]), 16'(w[15:8]));
      host_u.word_move(w & 16'h0080, 1'b0);
      step();
      check_word(16'(status_word[15:8]), 16'h0000);
    end
    // Alarm flag set from enabled points, range flag from any point; both cleared on request.
    n = $urandom_range(15);
    point_enable = 16'h0001 << n;
    point_alarm = ~point_enable;
    step_n(3);
    check_bit(status_word[STS_ALARM], 1'b0);
    point_alarm = point_enable;
    point_oor = point_enable;
    step_n(3);
    check_bit(status_word[STS_ALARM], 1'b1);
    check_bit(status_word[STS_OOR], 1'b1);
    {point_alarm, point_oor} = '0;
    host_u.word_move(16'h0020, 1'b0);
    step();
    check_bit(status_word[STS_ALARM], 1'b0);
    check_bit(status_word[STS_OOR], 1'b1);
    host_u.word_move(16'h0040, 1'b0);
    step();
    check_bit(status_word[STS_OOR], 1'b0);
    // Save, then a fresh start must come up with the saved word.
    d = 16'($urandom);
    n = $urandom_range(153, 46);
    host_u.block_write(8'(n), d, 1'b0);
    host_u.word_move(16'h0008, 1'b0);
    for (k = 0; k < 4 && nvm_busy !== 1'b1; k++) begin
      step();
    end
    for (k = 0; k < 200 && nvm_busy === 1'b1; k++) begin
      step();
    end
    check_word(16'(k), 16'h006C);
    host_u.word_move(16'h0000, 1'b0);
    resetn = 1'b0;
    step_n(12);
    resetn = 1'b1;
    wait_load();
    host_u.block_read(8'(n), 1'b0, got);
    check_word(got, d);
    // Heartbeat period, then a fault stops it.
    for (i = 0; i < 2; i++) begin
      hb = status_word[STS_GOOD];
      for (k = 0; k < 20 && status_word[STS_GOOD] === hb; k++) begin
        step();
      end
    end
    check_word(16'(k), 16'(HB));
    conv_fault = 1'b1;
    step();
    conv_fault = 1'b0;
    step_n(3);
    check_bit(status_word[STS_CONV_ERR], 1'b1);
    for (i = 0; i < 2; i++) begin
      step_n(HB + 1);
      check_bit(status_word[STS_GOOD], 1'b0);
    end
    print_verdict();
  end
endmodule // testbench
